// [sim/cfg_host_model.sv]
// Configuration software model: one-cycle read or write pulses.
// Assumes the block acks every request one cycle after it is taken.
`timescale 1ns/1ns
`default_nettype none
`include "link_pm_diag_consts.svh"
module cfg_host_model (
  input  wire logic        clk_in,
  input  wire logic [31:0] cfg_rdata_in,
  input  wire logic        cfg_ack_in,
  output logic             cfg_wr_out,
  output logic             cfg_rd_out,
  output logic      [7:0]  cfg_addr_out,
  output logic      [3:0]  cfg_be_out,
  output logic      [31:0] cfg_wdata_out
);
  initial begin
    cfg_wr_out = 1'b0;
    cfg_rd_out = 1'b0;
    cfg_addr_out = 8'h00;
    cfg_be_out = 4'h0;
    cfg_wdata_out = 32'h0;
  end
  task automatic cfg_op(input logic w, input logic [7:0] a, input logic [3:0] e, input logic [31:0] d,
                        output logic [31:0] q, output logic k);
    @(negedge clk_in);
    cfg_wr_out = w;
    cfg_rd_out = !w;
    cfg_addr_out = a;
    cfg_be_out = e;
    // Reserved first register bits 14:11 and 1:0 always go out as zero
    cfg_wdata_out = (a == `REG1_OFFSET) ? (d & 32'hFFFF87FC) : d;
    @(negedge clk_in);
    // Ack stands for one cycle only, so take the answer before releasing
    q = cfg_rdata_in;
    k = cfg_ack_in;
    cfg_wr_out = 1'b0;
    cfg_rd_out = 1'b0;
    // Released address and data lines show no stale value
    cfg_addr_out = ~cfg_addr_out;
    cfg_wdata_out = ~cfg_wdata_out;
  endtask
endmodule // cfg_host_model
`default_nettype wire

// [sim/link_pm_diag_checker.sv]
// Concurrent checks on the diagnostic register block, seen from its ports.
// Assumes ce_in stays high while reads are checked.
`timescale 1ns/1ns
`default_nettype none
`include "link_pm_diag_consts.svh"
module link_pm_diag_checker (
  input wire logic        clk_in,
  input wire logic        sys_rst_in,
  input wire logic        pcie_reset_input_n_in,
  input wire logic        global_reset_n_in,
  input wire logic        ce_in,
  input wire logic        cfg_wr_in,
  input wire logic        cfg_rd_in,
  input wire logic [7:0]  cfg_addr_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic        shared_clock_config_in,
  input wire logic        downstream_bus_reset_bit_in,
  input wire logic        sleep_state_in,
  input wire logic [2:0]  advertised_deep_idle_exit_latency_out,
  input wire logic [7:0]  training_seq_count_out,
  input wire logic        downstream_bus_reset_out,
  input wire logic        sleep_state_saving_out,
  input wire logic        first_window_enable_out,
  input wire logic        second_window_enable_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in || !pcie_reset_input_n_in || !global_reset_n_in);
  sequence s_rd(logic [7:0] a);
    ce_in && cfg_rd_in && !cfg_wr_in && cfg_addr_in == a;
  endsequence
  // Two quiet cycles so a lagging flop and the register agree
  sequence s_quiet_rd(logic [7:0] a);
    !cfg_wr_in ##1 s_rd(a);
  endsequence
  property p_res_hi;
    s_rd(`REG1_OFFSET) |=> cfg_rdata_out[31:21] == 11'h000;
  endproperty
  a_res_hi: assert property (p_res_hi) else $error("upper first register bits not zero");
  property p_lat_sep;
    s_rd(`REG1_OFFSET) ##0 shared_clock_config_in |=> advertised_deep_idle_exit_latency_out == cfg_rdata_out[20:18];
  endproperty
  a_lat_sep: assert property (p_lat_sep) else $error("latency mirror wrong, shared clock");
  property p_lat_shr;
    s_rd(`REG1_OFFSET) ##0 !shared_clock_config_in |=> advertised_deep_idle_exit_latency_out == cfg_rdata_out[17:15];
  endproperty
  a_lat_shr: assert property (p_lat_shr) else $error("latency mirror wrong, separate clock");
  property p_suppress;
    s_rd(`REG1_OFFSET) |=> downstream_bus_reset_out == ($past(downstream_bus_reset_bit_in) && !cfg_rdata_out[10]);
  endproperty
  a_suppress: assert property (p_suppress) else $error("downstream reset not masked right");
  property p_fts_sep;
    s_rd(`REG2_OFFSET) ##0 !shared_clock_config_in |=> training_seq_count_out == cfg_rdata_out[31:24];
  endproperty
  a_fts_sep: assert property (p_fts_sep) else $error("sequence count wrong, separate clock");
  property p_fts_shr;
    s_rd(`REG2_OFFSET) ##0 shared_clock_config_in |=> training_seq_count_out == cfg_rdata_out[23:16];
  endproperty
  a_fts_shr: assert property (p_fts_shr) else $error("sequence count wrong, shared clock");
  property p_save;
    s_rd(`REG2_OFFSET) |=> sleep_state_saving_out == ($past(sleep_state_in) && cfg_rdata_out[7]);
  endproperty
  a_save: assert property (p_save) else $error("sleep saving not gated by enable");
  property p_win;
    s_quiet_rd(`REG2_OFFSET) |=> {second_window_enable_out, first_window_enable_out} == cfg_rdata_out[6:5];
  endproperty
  a_win: assert property (p_win) else $error("window enables differ from register");
  property p_rev;
    s_rd(`REG2_OFFSET) |=> cfg_rdata_out[15:13] == `PHY_REVISION_FIELD_VALUE;
  endproperty
  a_rev: assert property (p_rev) else $error("revision field wrong");
endmodule // link_pm_diag_checker
bind link_pm_diag_registers link_pm_diag_checker i_chk (.*);
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench for the diagnostic register block.
// Assumes the host model drives all configuration traffic.
`timescale 1ns/1ns
`default_nettype none
`include "link_pm_diag_consts.svh"
module tb_top;
  logic        clk_in, sys_rst_in, pcie_reset_input_n_in, global_reset_n_in, shared_clock_config_in;
  logic        downstream_bus_reset_bit_in, link_idle_in, sleep_state_in, k;
  logic        ce_in = 1'b1;
  wire         cfg_wr_in, cfg_rd_in, cfg_ack_out, downstream_bus_reset_out, deep_idle_entry_req_out;
  wire         standby_entry_req_out, sleep_state_saving_out, first_window_enable_out, second_window_enable_out;
  wire         ask_retrain_out, ask_reconfigure_out, ask_hot_reset_out, ask_no_scramble_out, ask_loopback_out;
  wire  [7:0]  cfg_addr_in, training_seq_count_out;
  wire  [3:0]  cfg_be_in;
  wire  [31:0] cfg_wdata_in, cfg_rdata_out;
  wire  [2:0]  advertised_deep_idle_exit_latency_out;
  wire  [4:0]  link_number_out;
  logic [31:0] r1, r2, q;
  logic [7:0]  a;
  int          err_count, checks_done, cycles;

  cfg_host_model i_host (.clk_in(clk_in), .cfg_rdata_in(cfg_rdata_out), .cfg_ack_in(cfg_ack_out),
    .cfg_wr_out(cfg_wr_in), .cfg_rd_out(cfg_rd_in), .cfg_addr_out(cfg_addr_in), .cfg_be_out(cfg_be_in),
    .cfg_wdata_out(cfg_wdata_in));
  link_pm_diag_registers i_dut (.*);

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report;
    end
  end

  function automatic logic [31:0] upd(input logic [31:0] o, d, m, input logic [3:0] e);
    logic [31:0] w;
    w = m & {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}};
    return (o & ~w) | (d & w);
  endfunction
  function automatic logic in_win(input int n, input int b);
    // Zero means the request never rose
    return n > 0 && n >= b - 1 && n <= b + 4;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [3:0] e, input logic [31:0] d);
    i_host.cfg_op(1'b1, ad, e, d, q, k);
    if (ad == `REG1_OFFSET) r1 = upd(r1, d & 32'hFFFF87FC, `REG1_WR_MASK, e);
    if (ad == `REG2_OFFSET) r2 = upd(r2, d, `REG2_FUND_MASK | 32'hFF, e);
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e);
    i_host.cfg_op(1'b0, ad, 4'h0, 32'h0, q, k);
    chk("readback", q, e);
    chk("ack", 32'(k), 32'h1);
  endtask
  task automatic outs;
    chk("latency", 32'(advertised_deep_idle_exit_latency_out),
        32'(shared_clock_config_in ? r1[20:18] : r1[17:15]));
    chk("fts", 32'(training_seq_count_out), 32'(shared_clock_config_in ? r2[23:16] : r2[31:24]));
    chk("suppress", 32'(downstream_bus_reset_out), 32'(downstream_bus_reset_bit_in & ~r1[10]));
    chk("saving", 32'(sleep_state_saving_out), 32'(sleep_state_in & r2[7]));
    chk("windows", 32'({second_window_enable_out, first_window_enable_out}), 32'(r2[6:5]));
    chk("asks", 32'({link_number_out, ask_retrain_out, ask_reconfigure_out, ask_hot_reset_out,
        ask_no_scramble_out, ask_loopback_out}), 32'({r2[12:8], r2[4:0]}));
  endtask
  task automatic tmr(input logic [3:0] dl, input logic [3:0] sl);
    int n, nd, ns;
    logic [31:0] d;
    d = r1;
    d[9:6] = dl;
    d[5:2] = sl;
    wr(`REG1_OFFSET, 4'hF, d);
    link_idle_in = 1'b1;
    nd = 0;
    ns = 0;
    for (n = 1; n < 900 && (nd == 0 || ns == 0); n++) begin
      @(negedge clk_in);
      if (ns == 0 && standby_entry_req_out === 1'b1) ns = n;
      if (nd == 0 && deep_idle_entry_req_out === 1'b1) nd = n;
    end
    // Tick counts are averages, so allow a few cycles of slack
    chk("standby_time", 32'(in_win(ns, int'(sl) * 16 / 10)), 32'h1);
    chk("deep_time", 32'(in_win(nd, int'(dl) * 512 / 10)), 32'h1);
    link_idle_in = 1'b0;
    repeat (2) @(negedge clk_in);
    chk("reqs_drop", 32'({deep_idle_entry_req_out, standby_entry_req_out}), 32'h0);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    {pcie_reset_input_n_in, global_reset_n_in, shared_clock_config_in} = 3'b000;
    {downstream_bus_reset_bit_in, link_idle_in, sleep_state_in} = 3'b000;
    sys_rst_in = 1'b1;
    err_count = 0;
    checks_done = 0;
    cycles = 0;
    void'($urandom(26625));
    repeat (10) @(negedge clk_in);
    {sys_rst_in, pcie_reset_input_n_in, global_reset_n_in} = 3'b011;
    for (int p = 0; p < 3; p++) begin
      repeat (3) @(negedge clk_in);
      r1 = `REG1_RESET;
      r2 = `REG2_RESET;
      rd_chk(`REG1_OFFSET, r1);
      rd_chk(`REG2_OFFSET, r2);
      outs;
      if (p == 0) begin
        tmr(4'h4, 4'h2);
        tmr(4'hF, 4'h0);
        tmr(4'($urandom), 4'($urandom));
        for (int i = 0; i < 40; i++) begin
          a = (i % 3 == 0) ? `REG1_OFFSET : (i % 3 == 1) ? `REG2_OFFSET : 8'($urandom);
          if (i % 3 == 2 && (a == `REG1_OFFSET || a == `REG2_OFFSET)) a = 8'h00;
          wr(a, (i < 6) ? 4'hF : 4'($urandom), $urandom);
          {shared_clock_config_in, downstream_bus_reset_bit_in, sleep_state_in} = 3'($urandom);
          rd_chk(a, (a == `REG1_OFFSET) ? r1 : (a == `REG2_OFFSET) ? r2 : 32'h0);
          rd_chk(`REG1_OFFSET, r1);
          outs;
        end
        // Ordinary reset keeps the fundamental-reset fields
        sys_rst_in = 1'b1;
        @(negedge clk_in);
        sys_rst_in = 1'b0;
        r2[7:0] = 8'h00;
        @(negedge clk_in);
        rd_chk(`REG1_OFFSET, r1);
        rd_chk(`REG2_OFFSET, r2);
      end
      wr(`REG1_OFFSET, 4'hF, $urandom);
      wr(`REG2_OFFSET, 4'hF, $urandom);
      if (p == 1) pcie_reset_input_n_in = 1'b0;
      else global_reset_n_in = 1'b0;
      @(negedge clk_in);
      {pcie_reset_input_n_in, global_reset_n_in} = 2'b11;
    end
    final_report;
  end
endmodule // tb_top
`default_nettype wire

// [verilog/entry_timer.sv]
// Power-state entry timer counting programmed ticks while the link idles.
// Assumes idle comes from logic on clk_in; tick period is a whole number of ns.
`timescale 1ns/1ns
`default_nettype none
`include "link_pm_diag_consts.svh"
module entry_timer
  import link_pm_diag_pkg::*;
#(
  parameter int TICK_NS = 16
) (
  input  wire logic     clk_in,
  input  wire logic     ce_in,
  input  wire logic     rst_in,
  entry_timer_if.timer  tmr
);

  localparam logic [9:0] STEP = 10'(`CLK_PERIOD_NS);
  localparam logic [9:0] TICK = 10'(TICK_NS);

  entry_timer_state_type state;
  entry_timer_state_type next_state;
  logic [9:0]            acc;
  logic [9:0]            next_acc;
  logic [3:0]            ticks;
  logic [3:0]            next_ticks;

  // Phase accumulator keeps the average tick exact when it is not a whole cycle count
  wire logic [9:0] acc_sum  = acc + STEP;
  wire logic       tick_now = acc_sum >= TICK;
  wire logic [3:0] ticks_up = ticks + 4'h1;

  always_comb begin
    next_state = state;
    next_acc   = acc;
    next_ticks = ticks;
    unique case (state)
      TIMER_WAIT: begin
        next_acc   = 10'h000;
        next_ticks = 4'h0;
        if (tmr.idle) begin
          next_state = (tmr.limit == 4'h0) ? TIMER_DONE : TIMER_COUNT;
        end
      end
      TIMER_COUNT: begin
        if (!tmr.idle) begin
          next_state = TIMER_WAIT;
        end else begin
          next_acc = tick_now ? acc_sum - TICK : acc_sum;
          if (tick_now) begin
            next_ticks = ticks_up;
            if (ticks_up >= tmr.limit) begin
              next_state = TIMER_DONE;
            end
          end
        end
      end
      TIMER_DONE: begin
        if (!tmr.idle) begin
          next_state = TIMER_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state       <= TIMER_WAIT;
      acc         <= 10'h000;
      ticks       <= 4'h0;
      tmr.expired <= 1'b0;
    end else if (ce_in) begin
      state       <= next_state;
      acc         <= next_acc;
      ticks       <= next_ticks;
      tmr.expired <= next_state == TIMER_DONE;
    end
  end

endmodule // entry_timer
`default_nettype wire

// [verilog/entry_timer_if.sv]
// Link between the register block and one power-state entry timer.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ns
`default_nettype none
interface entry_timer_if;
  logic       idle;
  logic [3:0] limit;
  logic       expired;

  modport owner (output idle, output limit, input expired);
  modport timer (input idle, input limit, output expired);
endinterface
`default_nettype wire

// [verilog/link_pm_diag_consts.svh]
// Constants for the link power-management diagnostic register pair.
// Assumes byte offsets on the configuration port and a 100 MHz core clock.
`ifndef LINK_PM_DIAG_CONSTS_SVH
`define LINK_PM_DIAG_CONSTS_SVH

// Configuration offsets, byte addresses of aligned dwords
`define REG1_OFFSET          8'hC4
`define REG2_OFFSET          8'hC8

// Reset values
`define REG1_RESET           32'h00120108
`define REG2_RESET           32'h32142000
`define REG2_HOT_RESET       8'h00
`define LATENCY_RESET        3'h4
`define FTS_RESET            8'h14

// Writable bits
`define REG1_WR_MASK         32'h001FFFFF
`define REG2_FUND_MASK       32'hFFFF1F00

// First register fields
`define LAT_SEP_HI           20
`define LAT_SEP_LO           18
`define LAT_SHR_HI           17
`define LAT_SHR_LO           15
`define SUPPRESS_BIT         10
`define DEEP_TMR_HI          9
`define DEEP_TMR_LO          6
`define STBY_TMR_HI          5
`define STBY_TMR_LO          2

// Second register fields
`define FTS_SEP_HI           31
`define FTS_SEP_LO           24
`define FTS_SHR_HI           23
`define FTS_SHR_LO           16
`define PHY_REVISION_FIELD_LO           13
`define LINK_NUM_HI          12
`define LINK_NUM_LO          8
`define SLEEP_SAVE_BIT       7
`define WIN2_BIT             6
`define WIN1_BIT             5
`define RETRAIN_BIT          4
`define RECONF_BIT           3
`define HOT_RESET_BIT        2
`define NO_SCRAMBLE_BIT      1
`define LOOPBACK_BIT         0

// PHY revision, the reset-state value of the read-only field
`define PHY_REVISION_FIELD_VALUE        3'h1

// Timing
`define CLK_PERIOD_NS        10
`define DEEP_TICK_NS         512
`define STBY_CLK_MHZ_X10     625
`define STBY_TICK_NS         (10000 / `STBY_CLK_MHZ_X10)

`endif

// [verilog/link_pm_diag_pkg.sv]
// Types shared by the diagnostic register block and its entry timers.
// Assumes nothing beyond the constants header.
package link_pm_diag_pkg;

  typedef enum logic [1:0] {
    TIMER_WAIT,
    TIMER_COUNT,
    TIMER_DONE
  } entry_timer_state_type;

endpackage

// [verilog/link_pm_diag_registers.sv]
// Link power-management and PHY diagnostic configuration registers.
// Assumes configuration requests, link state and link control bits come from
// logic on clk_in; only the two reset pins arrive from outside the domain.
`timescale 1ns/1ns
`default_nettype none
`include "link_pm_diag_consts.svh"

module link_pm_diag_registers
  import link_pm_diag_pkg::*;
(
  // Clock, enable and resets
  input  wire logic        clk_in,
  input  wire logic        ce_in,
  input  wire logic        sys_rst_in,
  input  wire logic        pcie_reset_input_n_in,
  input  wire logic        global_reset_n_in,
  // Configuration access
  input  wire logic        cfg_wr_in,
  input  wire logic        cfg_rd_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [3:0]  cfg_be_in,
  input  wire logic [31:0] cfg_wdata_in,
  output logic      [31:0] cfg_rdata_out,
  output logic             cfg_ack_out,
  // Link state from the surrounding bridge
  input  wire logic        shared_clock_config_in,
  input  wire logic        downstream_bus_reset_bit_in,
  input  wire logic        link_idle_in,
  input  wire logic        sleep_state_in,
  // Results
  output logic      [2:0]  advertised_deep_idle_exit_latency_out,
  output logic      [7:0]  training_seq_count_out,
  output logic             downstream_bus_reset_out,
  output logic             deep_idle_entry_req_out,
  output logic             standby_entry_req_out,
  output logic             sleep_state_saving_out,
  output logic             first_window_enable_out,
  output logic             second_window_enable_out,
  output logic      [4:0]  link_number_out,
  output logic             ask_retrain_out,
  output logic             ask_reconfigure_out,
  output logic             ask_hot_reset_out,
  output logic             ask_no_scramble_out,
  output logic             ask_loopback_out
);

  // Reset structure
  logic [1:0]  fund_sync;
  logic [31:0] reg1;
  logic [31:0] reg2_fund;
  logic [7:0]  reg2_hot;
  logic [31:0] be_mask;

  // Either pin low asserts at once; release is synchronised to clk_in
  wire logic pin_rst_assert   = ~(pcie_reset_input_n_in & global_reset_n_in);
  wire logic fundamental_reset_n = fund_sync[1];
  wire logic fund_rst         = ~fundamental_reset_n;
  wire logic hot_rst          = fund_rst | sys_rst_in;

  always_ff @(posedge clk_in or posedge pin_rst_assert) begin
    if (pin_rst_assert) begin
      fund_sync <= 2'b00;
    end else if (ce_in) begin
      fund_sync <= {fund_sync[0], 1'b1};
    end
  end

  // Address decode and byte lanes
  wire logic hit1   = cfg_addr_in == `REG1_OFFSET;
  wire logic hit2   = cfg_addr_in == `REG2_OFFSET;
  wire logic wr1    = cfg_wr_in & hit1;
  wire logic wr2    = cfg_wr_in & hit2;
  wire logic access = cfg_wr_in | cfg_rd_in;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign be_mask[8*lane +: 8] = {8{cfg_be_in[lane]}};
    end
  endgenerate

  // Reserved upper bits are outside the write mask and stay zero
  wire logic [31:0] mask1      = be_mask & `REG1_WR_MASK;
  wire logic [31:0] mask2_fund = be_mask & `REG2_FUND_MASK;
  wire logic [7:0]  mask2_hot  = be_mask[7:0];

  // Bits 14:11 and 1:0 are kept as plain storage; zero is up to the programmer
  wire logic [31:0] next_reg1      = (reg1 & ~mask1) | (cfg_wdata_in & mask1);
  wire logic [31:0] next_reg2_fund = (reg2_fund & ~mask2_fund) | (cfg_wdata_in & mask2_fund);
  wire logic [7:0]  next_reg2_hot  = (reg2_hot & ~mask2_hot) | (cfg_wdata_in[7:0] & mask2_hot);

  // Fundamental-reset fields of the first register
  always_ff @(posedge clk_in or posedge fund_rst) begin
    if (fund_rst) begin
      reg1 <= `REG1_RESET;
    end else if (ce_in && wr1) begin
      reg1 <= next_reg1;
    end
  end

  // Fundamental-reset fields of the second register
  always_ff @(posedge clk_in or posedge fund_rst) begin
    if (fund_rst) begin
      reg2_fund <= `REG2_RESET & `REG2_FUND_MASK;
    end else if (ce_in && wr2) begin
      reg2_fund <= next_reg2_fund;
    end
  end

  // Low byte also clears on the ordinary reset
  always_ff @(posedge clk_in or posedge hot_rst) begin
    if (hot_rst) begin
      reg2_hot <= `REG2_HOT_RESET;
    end else if (ce_in && wr2) begin
      reg2_hot <= next_reg2_hot;
    end
  end

  // Field views
  wire logic [2:0] lat_sep   = reg1[`LAT_SEP_HI:`LAT_SEP_LO];
  wire logic [2:0] lat_shr   = reg1[`LAT_SHR_HI:`LAT_SHR_LO];
  wire logic       suppress  = reg1[`SUPPRESS_BIT];
  wire logic [3:0] deep_lim  = reg1[`DEEP_TMR_HI:`DEEP_TMR_LO];
  wire logic [3:0] stby_lim  = reg1[`STBY_TMR_HI:`STBY_TMR_LO];
  wire logic [7:0] fts_sep   = reg2_fund[`FTS_SEP_HI:`FTS_SEP_LO];
  wire logic [7:0] fts_shr   = reg2_fund[`FTS_SHR_HI:`FTS_SHR_LO];

  // Mirror selection follows the link control bit every cycle
  wire logic [2:0] next_latency = shared_clock_config_in ? lat_sep : lat_shr;
  wire logic [7:0] next_fts     = shared_clock_config_in ? fts_shr : fts_sep;
  wire logic       next_bus_rst = downstream_bus_reset_bit_in & ~suppress;
  wire logic       next_saving  = sleep_state_in & reg2_hot[`SLEEP_SAVE_BIT];

  // Read-only revision merged into the read path, never stored
  wire logic [31:0] rev_word  = {16'h0000, `PHY_REVISION_FIELD_VALUE, 13'h0000};
  wire logic [31:0] reg1_read = reg1 & `REG1_WR_MASK;
  wire logic [31:0] reg2_read = (reg2_fund & `REG2_FUND_MASK) | rev_word | {24'h000000, reg2_hot};
  wire logic [31:0] read_word = hit1 ? reg1_read : (hit2 ? reg2_read : 32'h00000000);

  // Derived outputs; latency and sequence count load reset values on fundamental reset with their fields, the other two also on ordinary reset
  always_ff @(posedge clk_in or posedge fund_rst) begin
    if (fund_rst) begin
      advertised_deep_idle_exit_latency_out <= `LATENCY_RESET;
      training_seq_count_out                <= `FTS_RESET;
    end else if (ce_in) begin
      advertised_deep_idle_exit_latency_out <= next_latency;
      training_seq_count_out                <= next_fts;
    end
  end

  always_ff @(posedge clk_in or posedge hot_rst) begin
    if (hot_rst) begin
      downstream_bus_reset_out <= 1'b0;
      sleep_state_saving_out   <= 1'b0;
    end else if (ce_in) begin
      downstream_bus_reset_out <= next_bus_rst;
      sleep_state_saving_out   <= next_saving;
    end
  end

  // Configuration answer one cycle after the request
  always_ff @(posedge clk_in or posedge hot_rst) begin
    if (hot_rst) begin
      cfg_rdata_out <= 32'h00000000;
      cfg_ack_out   <= 1'b0;
    end else if (ce_in) begin
      cfg_ack_out <= access;
      if (cfg_rd_in) begin
        cfg_rdata_out <= read_word;
      end
    end
  end

  // Register fields straight to their users
  assign first_window_enable_out  = reg2_hot[`WIN1_BIT];
  assign second_window_enable_out = reg2_hot[`WIN2_BIT];
  assign link_number_out          = reg2_fund[`LINK_NUM_HI:`LINK_NUM_LO];
  assign ask_retrain_out          = reg2_hot[`RETRAIN_BIT];
  assign ask_reconfigure_out      = reg2_hot[`RECONF_BIT];
  assign ask_hot_reset_out        = reg2_hot[`HOT_RESET_BIT];
  assign ask_no_scramble_out      = reg2_hot[`NO_SCRAMBLE_BIT];
  assign ask_loopback_out         = reg2_hot[`LOOPBACK_BIT];

  // Entry timers; odd tick periods would drift with a plain cycle divider
  entry_timer_if deep_if ();
  entry_timer_if stby_if ();

  assign deep_if.idle  = link_idle_in;
  assign deep_if.limit = deep_lim;
  assign stby_if.idle  = link_idle_in;
  assign stby_if.limit = stby_lim;

  entry_timer #(
    .TICK_NS (`DEEP_TICK_NS)
  ) u_deep_timer (
    .clk_in (clk_in),
    .ce_in  (ce_in),
    .rst_in (hot_rst),
    .tmr    (deep_if.timer)
  );

  entry_timer #(
    .TICK_NS (`STBY_TICK_NS)
  ) u_standby_timer (
    .clk_in (clk_in),
    .ce_in  (ce_in),
    .rst_in (hot_rst),
    .tmr    (stby_if.timer)
  );

  assign deep_idle_entry_req_out = deep_if.expired;
  assign standby_entry_req_out   = stby_if.expired;

endmodule // link_pm_diag_registers
`default_nettype wire
